// file: hdl/mss_pkg.sv
// constants, field layouts and types of the multi-step speed sequencer
// assumes a 10 MHz system clock and a 32-bit classic Wishbone slave port
package mss_pkg;
	// stage and table geometry
	localparam int STAGES = 15;
	localparam logic [3:0] LAST_STAGE = 4'he;
	localparam int ROW_W = 40;
	localparam int PRE_LSB = 0;
	localparam int DUR_LSB = 16;
	localparam int DR_LSB = 32;
	localparam logic [39:0] MASK_PRE = 40'h000000ffff;
	localparam logic [39:0] MASK_DUR = 40'h00ffff0000;
	localparam logic [39:0] MASK_DR = 40'hff00000000;
	localparam logic [7:0] DR_VALID = 8'h07;
	// register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_MAXF = 8'h08;
	localparam logic [7:0] OFS_RATEDV = 8'h0c;
	localparam logic [7:0] OFS_UPLIM = 8'h10;
	localparam logic [7:0] OFS_LOLIM = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_REMAIN = 8'h1c;
	// table selector in address bits 7:6
	localparam logic [1:0] TBL_PRE = 2'h1;
	localparam logic [1:0] TBL_DUR = 2'h2;
	localparam logic [1:0] TBL_DR = 2'h3;
	// mode word digit positions
	localparam int MODE_CYC_LSB = 0;
	localparam int MODE_UNIT_LSB = 4;
	localparam int MODE_RET_LSB = 8;
	localparam int MODE_START_LSB = 12;
	localparam logic [3:0] CYC_STOP = 4'h0;
	localparam logic [3:0] CYC_REPEAT = 4'h1;
	localparam logic [3:0] CYC_HOLD = 4'h2;
	// control register bit positions
	localparam int CTRL_SEQ_EN = 0;
	localparam int CTRL_TGT_LSB = 1;
	localparam int CTRL_LOWB = 3;
	// reset values
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] MAXF_RST = 16'h1388;
	localparam logic [15:0] RATEDV_RST = 16'h017c;
	localparam logic [15:0] UPLIM_RST = 16'h1388;
	localparam logic [15:0] LOLIM_RST = 16'h0000;
	localparam logic [15:0] DUR_RST = 16'h0064;
	localparam logic [15:0] DUR_MAX = 16'hfde8;
	localparam logic signed [15:0] PCT_FULL = 16'sh03e8;
	localparam logic [15:0] PRESET_RST [0:14] = '{
		16'h00c8, 16'h0190, 16'h0258, 16'h0320, 16'h03e8,
		16'h0320, 16'h0258, 16'h0190, 16'h00c8, 16'h0190,
		16'h0258, 16'h0320, 16'h03e8, 16'h0320, 16'h0258};
	// timing: one tick per tenth of the selected unit
	localparam int CLK_PERIOD_NS = 100;
	localparam int TENTH_SECOND_NS = 100_000_000;
	localparam int TENTH_CYCLES = TENTH_SECOND_NS / CLK_PERIOD_NS;
	localparam logic [11:0] UNIT_SEC = 12'h001;
	localparam logic [11:0] UNIT_MIN = 12'h03c;
	localparam logic [11:0] UNIT_HOUR = 12'he10;
	// sequencer states, gray along idle-fetch-load-run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD = 2'b11,
		ST_RUN = 2'b10
	} mss_state_t;
	// reference destinations
	typedef enum logic [1:0] {
		TGT_FREQ = 2'b00,
		TGT_VOLT = 2'b01,
		TGT_PID = 2'b10
	} mss_tgt_t;
	// default table row for a stage index
	function automatic logic [ROW_W-1:0] default_row(input int i);
		default_row = '0;
		if (i < STAGES) begin
			default_row = {8'h00, DUR_RST, PRESET_RST[i]};
		end
	endfunction
endpackage

// file: hdl/mss_sequencer.sv
// multi-reference table and fifteen-stage speed sequencer
// assumes a 10 MHz clock, sync inputs and a classic Wishbone master
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - fifteen presets, each up to 100.0 percent in magnitude
// - presets are signed, -100.0 to +100.0 percent
// - frequency target scales by maximum frequency
// - voltage target scales by rated motor voltage
// - process loop target passes percent unchanged
// - input terminal code picks the active preset
// - run starts stage one, advances on expiry
// - each stage has own time, direction, ramp
// - mode 0: after stage fifteen, zero, stop
// - zero-duration stages are skipped
// - mode 1: wrap to stage one forever
// - mode 2: hold last nonzero-time stage
// - unit digit: seconds, minutes or hours
// - retention digit keeps context over power loss
// - start digit 0: restart from stage one
// - start digit 1: resume remaining stage time
// - duration 0.0 to 6500.0, default 10.0
// - frequency clamped, low-limit behaviour applied
module mss_sequencer
	import mss_pkg::*;
#(
	parameter int TENTH_CYC = TENTH_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic RUN_CMD,
	input wire logic FAULT,
	input wire logic PWR_FAIL,
	input wire logic [3:0] DI_CODE,
	output logic [15:0] REF_OUT,
	output logic REF_REVERSE,
	output logic [1:0] RAMP_SEL,
	output logic SEQ_ACTIVE,
	output logic [3:0] SEQ_STAGE,
	output logic SEQ_DONE
);
	localparam int CW = $clog2(TENTH_CYC);

	// merge a 16-bit register with the low two byte lanes
	function automatic logic [15:0] merge16(input logic [15:0] o,
		input logic [15:0] n, input logic [1:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (n & m);
	endfunction

	// limit a signed percentage to plus or minus full scale
	function automatic logic [15:0] clamp_pct(input logic [15:0] v);
		logic signed [15:0] s;
		s = $signed(v);
		if (s > PCT_FULL) return PCT_FULL;
		if (s < -PCT_FULL) return -PCT_FULL;
		return v;
	endfunction

	// signed percentage times a full-scale value
	function automatic logic [15:0] scale(input logic [15:0] p,
		input logic [14:0] full);
		logic signed [31:0] prod;
		prod = $signed({{16{p[15]}}, p}) * $signed({17'h00000, full});
		prod = prod / 32'sh000003e8;
		return prod[15:0];
	endfunction

	// bus and configuration registers
	logic pend_q;
	logic [15:0] mode_q;
	logic [15:0] ctrl_q;
	logic [15:0] maxf_q;
	logic [15:0] ratedv_q;
	logic [15:0] uplim_q;
	logic [15:0] lolim_q;
	// sequencer state
	mss_state_t state_q, state_d;
	logic [3:0] stage_q, stage_d;
	logic [3:0] nz_q, nz_d;
	logic [15:0] remain_q, remain_d;
	logic [15:0] pre_q, pre_d;
	logic [7:0] dr_q, dr_d;
	logic hold_q, hold_d;
	logic done_q, done_d;
	logic resume_q, resume_d;
	logic any_q, any_d;
	logic run_prev_q;
	logic adv;
	// timing prescaler
	logic [CW-1:0] tenth_q;
	logic [11:0] unit_q;

	mss_tbl_if tbl();

	// stage table
	mss_tbl_mem #(.DEPTH(16)) u_mem (
		.clk(CLOCK),
		.rst_n(RST_N),
		.t(tbl)
	);

	// bus decode
	wire req = WB_CYC_I & WB_STB_I;
	wire aligned = WB_ADR_I[1:0] == 2'b00;
	wire [1:0] tsel = WB_ADR_I[7:6];
	wire [3:0] tidx = WB_ADR_I[5:2];
	wire tbl_hit = aligned && tsel != 2'b00 && tidx != 4'hf;
	wire hit_mode = WB_ADR_I == OFS_MODE;
	wire hit_ctrl = WB_ADR_I == OFS_CTRL;
	wire hit_maxf = WB_ADR_I == OFS_MAXF;
	wire hit_ratedv = WB_ADR_I == OFS_RATEDV;
	wire hit_uplim = WB_ADR_I == OFS_UPLIM;
	wire hit_lolim = WB_ADR_I == OFS_LOLIM;
	wire hit_status = WB_ADR_I == OFS_STATUS;
	wire hit_remain = WB_ADR_I == OFS_REMAIN;
	// writes commit at the edge where the master samples ack
	wire wr_fire = req & WB_WE_I & WB_ACK_O;
	wire [1:0] lanes = WB_SEL_I[1:0];

	// table field addressed by the bus, from read port a
	wire [15:0] old_f = (tsel == TBL_PRE) ? tbl.a_data[PRE_LSB+:16]
		: (tsel == TBL_DUR) ? tbl.a_data[DUR_LSB+:16]
		: {8'h00, tbl.a_data[DR_LSB+:8]};
	wire [15:0] mrg_f = merge16(old_f, WB_DAT_I[15:0], lanes);
	// written values are forced into range
	wire [15:0] new_f = (tsel == TBL_PRE) ? clamp_pct(mrg_f)
		: (tsel == TBL_DUR) ? ((mrg_f > DUR_MAX) ? DUR_MAX : mrg_f)
		: {8'h00, mrg_f[7:0] & DR_VALID};
	assign tbl.a_idx = tidx;
	assign tbl.wr_idx = tidx;
	assign tbl.wr_en = wr_fire & tbl_hit;
	assign tbl.wr_data = {new_f[7:0], new_f, new_f};
	assign tbl.wr_mask = (tsel == TBL_PRE) ? MASK_PRE
		: (tsel == TBL_DUR) ? MASK_DUR : MASK_DR;

	// read selection; unmapped offsets read zero
	wire [15:0] status_w = {8'h00, done_q, hold_q, resume_q,
		state_q != ST_IDLE, stage_q};
	wire [15:0] rd16 = tbl_hit ? old_f
		: hit_mode ? mode_q
		: hit_ctrl ? ctrl_q
		: hit_maxf ? maxf_q
		: hit_ratedv ? ratedv_q
		: hit_uplim ? uplim_q
		: hit_lolim ? lolim_q
		: hit_status ? status_w
		: hit_remain ? remain_q : 16'h0000;

	// two-cycle answer: pending, then one-cycle ack
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			pend_q <= 1'b0;
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			pend_q <= req & ~pend_q & ~WB_ACK_O;
			WB_ACK_O <= req & pend_q;
			if (req & pend_q) begin
				WB_DAT_O <= WB_WE_I ? 32'h00000000 : {16'h0000, rd16};
			end
		end
	end

	// configuration registers with byte lanes
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			mode_q <= MODE_RST;
			ctrl_q <= CTRL_RST;
			maxf_q <= MAXF_RST;
			ratedv_q <= RATEDV_RST;
			uplim_q <= UPLIM_RST;
			lolim_q <= LOLIM_RST;
		end else if (wr_fire) begin
			if (hit_mode) mode_q <= merge16(mode_q, WB_DAT_I[15:0], lanes);
			if (hit_ctrl) ctrl_q <= merge16(ctrl_q, WB_DAT_I[15:0], lanes);
			if (hit_maxf) maxf_q <= merge16(maxf_q, WB_DAT_I[15:0], lanes);
			if (hit_ratedv) ratedv_q <= merge16(ratedv_q, WB_DAT_I[15:0], lanes);
			if (hit_uplim) uplim_q <= merge16(uplim_q, WB_DAT_I[15:0], lanes);
			if (hit_lolim) lolim_q <= merge16(lolim_q, WB_DAT_I[15:0], lanes);
		end
	end

	// mode digits and control fields
	wire seq_en = ctrl_q[CTRL_SEQ_EN];
	wire [1:0] tgt = ctrl_q[CTRL_TGT_LSB+:2];
	wire low_zero = ctrl_q[CTRL_LOWB];
	wire [3:0] cyc_m = mode_q[MODE_CYC_LSB+:4];
	wire [3:0] unit_m = mode_q[MODE_UNIT_LSB+:4];
	wire [3:0] ret_m = mode_q[MODE_RET_LSB+:4];
	wire [3:0] start_m = mode_q[MODE_START_LSB+:4];
	// current row on read port b
	wire [15:0] b_pre = tbl.b_data[PRE_LSB+:16];
	wire [15:0] b_dur = tbl.b_data[DUR_LSB+:16];
	wire [7:0] b_dr = tbl.b_data[DR_LSB+:8];
	// terminal code n selects preset n; code 0 selects none
	assign tbl.b_idx = seq_en ? stage_q : DI_CODE - 4'h1;
	// run edge starts, any loss of run interrupts
	wire start = RUN_CMD & ~run_prev_q & seq_en & ~FAULT & ~PWR_FAIL;
	wire intr = ~RUN_CMD | FAULT | PWR_FAIL | ~seq_en;
	wire resume_ok = resume_q && start_m == 4'h1;

	// prescaler: tenth of a second, then tenths per unit
	wire tick_run = state_q == ST_RUN && !hold_q;
	wire tenth_end = tenth_q == CW'(TENTH_CYC - 1);
	wire [11:0] unit_len = (unit_m == 4'h1) ? UNIT_MIN
		: (unit_m == 4'h2) ? UNIT_HOUR : UNIT_SEC;
	wire stage_tick = tick_run & tenth_end
		& (unit_q == unit_len - 12'h001);

	// prescaler restarts on every stage load
	always_ff @(posedge CLOCK) begin
		if (!RST_N || !tick_run) begin
			tenth_q <= '0;
			unit_q <= 12'h000;
		end else if (tenth_end) begin
			tenth_q <= '0;
			unit_q <= stage_tick ? 12'h000 : unit_q + 12'h001;
		end else begin
			tenth_q <= tenth_q + CW'(1);
		end
	end

	// stage sequencing
	always_comb begin
		state_d = state_q;
		stage_d = stage_q;
		nz_d = nz_q;
		remain_d = remain_q;
		pre_d = pre_q;
		dr_d = dr_q;
		hold_d = hold_q;
		done_d = done_q;
		resume_d = resume_q;
		any_d = any_q;
		adv = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					done_d = 1'b0;
					resume_d = 1'b0;
					if (resume_ok) begin
						state_d = ST_RUN;
					end else begin
						stage_d = 4'h0;
						hold_d = 1'b0;
						any_d = 1'b0;
						state_d = ST_FETCH;
					end
				end
			end
			ST_FETCH: state_d = ST_LOAD;
			ST_LOAD: begin
				if (b_dur == 16'h0000) begin
					adv = 1'b1;
				end else begin
					remain_d = b_dur;
					pre_d = b_pre;
					dr_d = b_dr;
					any_d = 1'b1;
					nz_d = stage_q;
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stage_tick) begin
					if (remain_q <= 16'h0001) adv = 1'b1;
					else remain_d = remain_q - 16'h0001;
				end
			end
		endcase
		if (adv) begin
			remain_d = 16'h0000;
			if (stage_q != LAST_STAGE) begin
				stage_d = stage_q + 4'h1;
				state_d = ST_FETCH;
			end else if (cyc_m == CYC_REPEAT) begin
				stage_d = 4'h0;
				any_d = 1'b0;
				state_d = ST_FETCH;
			end else if (cyc_m == CYC_HOLD && any_q) begin
				stage_d = nz_q;
				hold_d = 1'b1;
				state_d = ST_RUN;
			end else begin
				state_d = ST_IDLE;
				done_d = 1'b1;
			end
		end
		// interruption keeps context only from a running stage
		if (state_q != ST_IDLE && intr) begin
			state_d = ST_IDLE;
			resume_d = state_q == ST_RUN;
		end
		if (PWR_FAIL && ret_m != 4'h1) begin
			resume_d = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			stage_q <= 4'h0;
			nz_q <= 4'h0;
			remain_q <= 16'h0000;
			pre_q <= 16'h0000;
			dr_q <= 8'h00;
			hold_q <= 1'b0;
			done_q <= 1'b0;
			resume_q <= 1'b0;
			any_q <= 1'b0;
			run_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stage_q <= stage_d;
			nz_q <= nz_d;
			remain_q <= remain_d;
			pre_q <= pre_d;
			dr_q <= dr_d;
			hold_q <= hold_d;
			done_q <= done_d;
			resume_q <= resume_d;
			any_q <= any_d;
			run_prev_q <= RUN_CMD;
		end
	end

	// reference path: select, scale, limit
	wire ref_on = seq_en ? state_q == ST_RUN : DI_CODE != 4'h0;
	wire [15:0] pct = seq_en ? pre_q : b_pre;
	wire [15:0] f_raw = scale(pct, maxf_q[14:0]);
	wire [15:0] v_raw = scale(pct, ratedv_q[14:0]);
	wire f_neg = f_raw[15];
	wire [15:0] f_mag = f_neg ? 16'h0000 - f_raw : f_raw;
	wire [15:0] f_lim = (f_mag > uplim_q) ? uplim_q
		: (f_mag < lolim_q) ? (low_zero ? 16'h0000 : lolim_q)
		: f_mag;
	wire [15:0] f_out = f_neg ? 16'h0000 - f_lim : f_lim;
	wire [15:0] ref_d = !ref_on ? 16'h0000
		: (tgt == TGT_VOLT) ? v_raw
		: (tgt == TGT_PID) ? pct
		: f_out;

	// registered outputs toward the drive
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			REF_OUT <= 16'h0000;
			REF_REVERSE <= 1'b0;
			RAMP_SEL <= 2'h0;
			SEQ_ACTIVE <= 1'b0;
			SEQ_STAGE <= 4'h1;
			SEQ_DONE <= 1'b0;
		end else begin
			REF_OUT <= ref_d;
			REF_REVERSE <= seq_en & ref_on & dr_q[0];
			RAMP_SEL <= (seq_en & ref_on) ? dr_q[2:1] : 2'h0;
			SEQ_ACTIVE <= state_d != ST_IDLE;
			SEQ_STAGE <= stage_d + 4'h1;
			SEQ_DONE <= done_d;
		end
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	AST_START_STAGE1: assert property (
		state_q == ST_IDLE && start && !resume_ok
		|=> state_q == ST_FETCH && stage_q == 4'h0 ##1 state_q == ST_LOAD)
		else $error("fresh start did not fetch stage one");
	AST_SKIP_ZERO: assert property (
		state_q == ST_LOAD && b_dur == 16'h0000 && stage_q != LAST_STAGE
		&& !intr |=> state_q == ST_FETCH && stage_q == $past(stage_q) + 4'h1)
		else $error("zero-duration stage not skipped");
	AST_LOAD_STAGE: assert property (
		state_q == ST_LOAD && b_dur != 16'h0000 && !intr
		|=> state_q == ST_RUN && remain_q == $past(b_dur)
		&& dr_q == $past(b_dr))
		else $error("stage time or direction not loaded");
	AST_MODE0_END: assert property (
		state_q == ST_RUN && stage_tick && remain_q <= 16'h0001
		&& stage_q == LAST_STAGE && cyc_m == CYC_STOP && !intr
		|=> state_q == ST_IDLE && done_q ##1 REF_OUT == 16'h0000)
		else $error("single cycle did not stop at zero");
	AST_MODE1_WRAP: assert property (
		state_q == ST_RUN && stage_tick && remain_q <= 16'h0001
		&& stage_q == LAST_STAGE && cyc_m == CYC_REPEAT && !intr
		|=> state_q == ST_FETCH && stage_q == 4'h0)
		else $error("repeat mode did not wrap");
	AST_MODE2_HOLD: assert property (
		state_q == ST_RUN && hold_q && !intr
		|=> state_q == ST_RUN && hold_q && stage_q == $past(stage_q))
		else $error("hold mode left the final stage");
	AST_TICK_DEC: assert property (
		state_q == ST_RUN && stage_tick && remain_q > 16'h0001 && !intr
		|=> remain_q == $past(remain_q) - 16'h0001)
		else $error("remaining time not decremented");
	AST_STOP_RECORD: assert property (
		state_q == ST_RUN && !RUN_CMD && !PWR_FAIL
		|=> state_q == ST_IDLE && resume_q && !SEQ_ACTIVE)
		else $error("stop not recorded as interruption");
	AST_RESUME: assert property (
		state_q == ST_IDLE && start && resume_ok
		|=> state_q == ST_RUN && remain_q == $past(remain_q)
		&& stage_q == $past(stage_q))
		else $error("resume lost stage or time");

	COV_WRAP: cover property (state_q == ST_RUN && stage_tick
		&& stage_q == LAST_STAGE && cyc_m == CYC_REPEAT);
	COV_HOLD: cover property (!hold_q ##1 hold_q);
	COV_RESUME: cover property (state_q == ST_IDLE && start && resume_ok);
	COV_SKIP: cover property (state_q == ST_LOAD && b_dur == 16'h0000);
endmodule

// file: hdl/mss_tbl_if.sv
// carrier between the sequencer and its stage table memory
// assumes one clock; both read ports have one cycle of latency
`timescale 1ns/1ns
interface mss_tbl_if;
	import mss_pkg::*;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [ROW_W-1:0] wr_data;
	logic [ROW_W-1:0] wr_mask;
	logic [3:0] a_idx;
	logic [ROW_W-1:0] a_data;
	logic [3:0] b_idx;
	logic [ROW_W-1:0] b_data;
	modport mem(input wr_en, wr_idx, wr_data, wr_mask, a_idx, b_idx,
		output a_data, b_data);
	modport user(output wr_en, wr_idx, wr_data, wr_mask, a_idx, b_idx,
		input a_data, b_data);
endinterface

// file: hdl/mss_tbl_mem.sv
// stage table: preset, duration and direction/ramp per stage
// assumes synchronous active-low reset; read data come from registers
`timescale 1ns/1ns
module mss_tbl_mem
	import mss_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	mss_tbl_if.mem t
);
	// table rows, reloaded with defaults at reset
	logic [ROW_W-1:0] row_q [DEPTH];
	// registered read ports
	logic [ROW_W-1:0] a_q;
	logic [ROW_W-1:0] b_q;

	// masked write, two registered reads
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				row_q[i] <= default_row(i);
			end
		end else if (t.wr_en) begin
			row_q[t.wr_idx] <= (row_q[t.wr_idx] & ~t.wr_mask)
				| (t.wr_data & t.wr_mask);
		end
	end

	// read ports see old data on a same-cycle write
	always_ff @(posedge clk) begin
		a_q <= row_q[t.a_idx];
		b_q <= row_q[t.b_idx];
	end

	assign t.a_data = a_q;
	assign t.b_data = b_q;
endmodule

// file: sim/mss_drive_model.sv
// model of the run command source and the speed reference path
// assumes the bench raises its requests just after a rising edge
`timescale 1ns/1ns
module mss_drive_model (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic run_req,
	input wire logic fault_req,
	input wire logic pwr_req,
	input wire logic clear,
	input wire logic [15:0] REF_OUT,
	input wire logic SEQ_ACTIVE,
	input wire logic [3:0] SEQ_STAGE,
	output logic RUN_CMD,
	output logic FAULT,
	output logic PWR_FAIL,
	output logic [14:0] seen_q,
	output int wraps
);
	logic [3:0] last_q; // stage of the previous cycle
	logic act_q; // activity of the previous cycle
	// quiet command lines from time zero
	initial begin
		RUN_CMD = 1'b0;
		FAULT = 1'b0;
		PWR_FAIL = 1'b0;
	end
	// command terminals follow requests one edge later
	always @(posedge CLOCK) begin
		RUN_CMD <= run_req & RST_N;
		FAULT <= fault_req;
		PWR_FAIL <= pwr_req;
	end
	// log stages that drove a reference, count wraps
	// the reference lags the stage number by one cycle
	always @(posedge CLOCK) begin
		if (clear) begin
			seen_q <= '0;
			wraps <= 0;
		end else if (SEQ_ACTIVE === 1'b1) begin
			if (REF_OUT !== 16'h0000)
				seen_q[last_q - 4'h1] <= 1'b1;
			// a fresh start from idle is not a wrap
			if (act_q === 1'b1 && last_q == 4'hf && SEQ_STAGE == 4'h1)
				wraps <= wraps + 1;
		end
		last_q <= SEQ_STAGE;
		act_q <= SEQ_ACTIVE;
	end
endmodule

// file: sim/multi_step_speed_sequencer_test.sv
// self-checking bench: register map, presets and stage sequencing
// assumes the design files and the drive model are compiled first
`timescale 1ns/1ns
module multi_step_speed_sequencer_test;
	import mss_pkg::*;
	localparam int TC = 4; // shortened tenth-unit prescale
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, run_cmd, fault, pwr_fail, ref_rev, seq_active, seq_done;
	logic run_req = 1'b0, fault_req = 1'b0, pwr_req = 1'b0, clear = 1'b1;
	logic [3:0] di_code = 4'h0;
	logic [3:0] seq_stage;
	logic [1:0] ramp_sel;
	logic [15:0] ref_out, q;
	logic [14:0] seen;
	int wraps, n, i, cycles = 0, miscompares = 0, num_checks = 0;
	// interruption cases: mode word, kind, expected stage on restart
	logic [15:0] rmode [0:3] = '{16'h1000, 16'h0000, 16'h1000, 16'h1100};
	int kind [0:3] = '{0, 1, 2, 2};
	logic [3:0] rexp [0:3] = '{4'h3, 4'h1, 4'h1, 4'h3};

	mss_sequencer #(.TENTH_CYC(TC)) mss_sequencer_i (.CLOCK(clock),
		.RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .RUN_CMD(run_cmd), .FAULT(fault),
		.PWR_FAIL(pwr_fail), .DI_CODE(di_code), .REF_OUT(ref_out),
		.REF_REVERSE(ref_rev), .RAMP_SEL(ramp_sel), .SEQ_ACTIVE(seq_active),
		.SEQ_STAGE(seq_stage), .SEQ_DONE(seq_done));
	mss_drive_model mss_drive_model_i (.CLOCK(clock), .RST_N(rst_n),
		.run_req(run_req), .fault_req(fault_req), .pwr_req(pwr_req),
		.clear(clear), .REF_OUT(ref_out), .SEQ_ACTIVE(seq_active),
		.SEQ_STAGE(seq_stage), .RUN_CMD(run_cmd), .FAULT(fault),
		.PWR_FAIL(pwr_fail), .seen_q(seen), .wraps(wraps));

	// 10 MHz clock
	initial begin
		forever #50 clock = ~clock;
	end
	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	// verdict and end of run
	task results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// compare sixteen-bit values
	task chk16(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// compare single flags
	task chk1(input logic g, input logic e);
		chk16({15'h0, g}, {15'h0, e});
	endtask
	// one classic cycle, held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= {16'h0000, d};
		do begin
			@(posedge clock);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50)
			miscompares++;
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		wb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0000);
		chk16(q, e);
	endtask
	// terminal code, then the settled reference
	task di(input logic [3:0] c, input logic [15:0] e);
		di_code <= c;
		repeat (4) @(posedge clock);
		chk16(ref_out, e);
	endtask
	// wait until a stage drives its reference
	task wait_ref(input logic [3:0] s);
		int k;
		for (k = 0; k < 2000 && !(seq_stage === s && ref_out !== 0); k++)
			@(posedge clock);
		if (k >= 2000)
			miscompares++;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		clear <= 1'b0;
		rd(OFS_MODE, MODE_RST);
		rd(OFS_MAXF, MAXF_RST);
		rd(8'h80, DUR_RST);
		for (i = 0; i < STAGES; i++)
			rd(8'h40 + 8'(4 * i), PRESET_RST[i]);
		rd(8'h7c, 16'h0000);
		wr(8'h80, 16'hffff);
		rd(8'h80, DUR_MAX);
		wr(8'h44, 16'h07d0);
		rd(8'h44, 16'h03e8);
		wr(8'h40, 16'hfe0c);
		rd(8'h40, 16'hfe0c);
		// presets by terminal code, process loop target
		wr(OFS_CTRL, 16'h0004);
		for (i = 3; i <= STAGES; i++)
			di(4'(i), PRESET_RST[i - 1]);
		di(4'h1, 16'hfe0c);
		di(4'h0, 16'h0000);
		// frequency and voltage scaling, limits
		wr(OFS_CTRL, 16'h0000);
		di(4'h1, 16'hf63c);
		di(4'h5, 16'h1388);
		wr(OFS_CTRL, 16'h0002);
		di(4'h5, 16'h017c);
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_UPLIM, 16'h01f4);
		di(4'h5, 16'h01f4);
		di(4'h1, 16'hfe0c);
		wr(OFS_UPLIM, 16'h1388);
		wr(OFS_LOLIM, 16'h07d0);
		di(4'h3, 16'h0bb8);
		di(4'h9, 16'h07d0);
		wr(OFS_CTRL, 16'h0008);
		di(4'h9, 16'h0000);
		wr(OFS_LOLIM, 16'h0000);
		di_code <= 4'h0;
		// one pass, stage two skipped
		for (i = 0; i < STAGES; i++)
			wr(8'h80 + 8'(4 * i), (i == 1) ? 16'h0000 : 16'h0001);
		wr(8'hc0, 16'h0007);
		wr(OFS_CTRL, 16'h0005);
		run_req <= 1'b1;
		wait_ref(4'h1);
		chk1(ref_rev, 1'b1);
		chk16({14'h0, ramp_sel}, 16'h0003);
		chk16(ref_out, 16'hfe0c);
		for (n = 0; n < 2000 && seq_done !== 1'b1; n++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		chk1(seq_done, 1'b1);
		chk16(ref_out, 16'h0000);
		chk16({1'b0, seen}, 16'h7ffd);
		run_req <= 1'b0;
		repeat (4) @(posedge clock);
		// repeating passes, then a stop
		wr(OFS_MODE, 16'h0001);
		run_req <= 1'b1;
		for (n = 0; n < 3000 && wraps < 2; n++)
			@(posedge clock);
		chk16(16'(wraps), 16'h0002);
		chk1(seq_active, 1'b1);
		run_req <= 1'b0;
		repeat (4) @(posedge clock);
		chk1(seq_active, 1'b0);
		chk16(ref_out, 16'h0000);
		// minutes as stage unit
		wr(OFS_MODE, 16'h0010);
		run_req <= 1'b1;
		repeat (150) @(posedge clock);
		chk16(ref_out, 16'hfe0c);
		wait_ref(4'h3);
		chk16({12'h0, seq_stage}, 16'h0003);
		run_req <= 1'b0;
		pwr_req <= 1'b1;
		repeat (4) @(posedge clock);
		pwr_req <= 1'b0;
		// power loss without retention drops the resume context
		rd(OFS_STATUS, 16'h0002);
		rd(OFS_REMAIN, 16'h0001);
		// interruptions and restart modes
		wr(8'h88, 16'h0032);
		for (i = 0; i < 4; i++) begin
			wr(OFS_MODE, rmode[i]);
			run_req <= 1'b1;
			wait_ref(4'h3);
			repeat (10) @(posedge clock);
			if (kind[i] == 0)
				run_req <= 1'b0;
			else if (kind[i] == 1)
				fault_req <= 1'b1;
			else
				pwr_req <= 1'b1;
			repeat (4) @(posedge clock);
			chk1(seq_active, 1'b0);
			run_req <= 1'b0;
			fault_req <= 1'b0;
			pwr_req <= 1'b0;
			repeat (3) @(posedge clock);
			run_req <= 1'b1;
			repeat (6) @(posedge clock);
			chk16({12'h0, seq_stage}, {12'h0, rexp[i]});
			run_req <= 1'b0;
			repeat (4) @(posedge clock);
		end
		// hold the last stage with nonzero time
		wr(8'h88, 16'h0001);
		wr(8'hb4, 16'h0000);
		wr(8'hb8, 16'h0000);
		wr(OFS_MODE, 16'h0002);
		run_req <= 1'b1;
		repeat (400) @(posedge clock);
		chk16({12'h0, seq_stage}, 16'h000d);
		chk16(ref_out, PRESET_RST[12]);
		chk1(seq_active, 1'b1);
		run_req <= 1'b0;
		repeat (4) @(posedge clock);
		results();
	end
endmodule
